// *** core/acrb_top.sv ***
`include "acrb_cfg.svh"

module acrb_top
  import acrb_pkg::*;
#(
  parameter int DATA_W = 14
) (
  input  wire logic              clk,              // Core clock, the converter input clock.
  input  wire logic              sys_rst,          // Synchronous reset, active high.
  input  wire logic              reg_wr,           // Register write strobe.
  input  wire logic              reg_rd,           // Register read strobe.
  input  wire logic [8:0]        reg_addr,         // Register address.
  input  wire logic [7:0]        reg_wdata,        // Register write data.
  output logic      [7:0]        reg_rdata,        // Register read data.
  output logic                   reg_rd_valid,     // Read data present.
  input  wire logic              sync_in,          // Sync pulse from the pin.
  input  wire logic [2:0]        div_ratio,        // Divide ratio minus one.
  output logic                   div_tick,         // Divided clock tick.
  input  wire logic [1:0]        smp_valid,        // Conversion result present, per channel.
  input  wire logic [1:0][DATA_W-1:0] smp_data,    // Conversion results, per channel.
  output logic      [1:0]        out_valid,        // Corrected result present, per channel.
  output logic [1:0][DATA_W-1:0] out_data,         // Corrected results, per channel.
  output logic      [1:0]        out_enable,       // Output drivers on, per channel.
  output logic                   out_lvds,         // LVDS signalling selected.
  output logic                   lvds_reduced,     // Reduced-swing LVDS selected.
  output logic                   out_interleave,   // CMOS interleave selected.
  output logic      [1:0]        out_code_format,  // Output number format.
  output logic                   dco_invert,       // Invert the data clock output.
  output logic      [4:0]        dco_delay_code,   // Data clock output delay code.
  output logic      [11:0]       dco_delay_ps,     // Data clock output delay in picoseconds.
  output logic      [1:0]        ref_span,         // Full-scale span selection.
  output logic                   st_enable,        // Self-test running.
  output logic                   st_restart,       // Self-test sequence reset.
  output logic                   cm_servo_en,      // Common-mode servo on.
  output logic      [1:0]        dither_en,        // Dither on, per channel.
  output logic                   sync_master_en    // Sync circuitry powered.
);

  acrb_bank_type st_reg;
  acrb_bank_type st_next;
  logic [1:0][15:0] chan_sig;

  // Delay in picoseconds, rounded to the nearest whole picosecond.
  function automatic logic [11:0] dco_ps(input logic [4:0] code);
    int prod;
    prod   = `ACRB_DCO_FULL_PS * int'(code) + (`ACRB_DCO_STEPS / 2);
    dco_ps = 12'(prod / `ACRB_DCO_STEPS);
  endfunction : dco_ps

  // Index of the channel that answers a read of a local register.
  function automatic int read_chan(input logic [1:0] index);
    read_chan = index[`ACRB_CHAN_A] ? `ACRB_CHAN_A : `ACRB_CHAN_B;
  endfunction : read_chan

  // ========================================================================
  // Per-channel data paths.
  // ========================================================================
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    acrb_chan_path #(
      .DATA_W (DATA_W)
    ) u_path (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .smp_valid  (smp_valid[ch]),
      .smp_data   (smp_data[ch]),
      .offset     (st_reg.offset_trim[ch]),
      .invert     (st_reg.out_invert[ch]),
      .st_enable  (st_enable),
      .st_restart (st_restart),
      .out_valid  (out_valid[ch]),
      .out_data   (out_data[ch]),
      .signature  (chan_sig[ch])
    );
  end

  // ========================================================================
  // Register writes, reads, sync handling and the input clock divider.
  // ========================================================================
  always_comb begin
    int  rc;
    logic sync_gated;
    logic wr_sync;
    rc         = read_chan(st_reg.chan_index);
    sync_gated = 1'b0;
    wr_sync    = 1'b0;
    st_next    = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.div_tick = 1'b0;

    // Writes; local registers touch only the channels picked by the index.
    if (reg_wr) begin
      case (reg_addr)
        `ACRB_ADDR_CHAN_INDEX: begin
          st_next.chan_index = reg_wdata[1:0];
        end
        `ACRB_ADDR_SELF_TEST: begin
          st_next.self_test = reg_wdata;
        end
        `ACRB_ADDR_ANALOG_IN: begin
          st_next.analog_in = reg_wdata;
        end
        `ACRB_ADDR_OFFSET_TRIM: begin
          for (int ch = 0; ch < 2; ch++) begin
            if (st_reg.chan_index[ch]) begin
              st_next.offset_trim[ch] = reg_wdata;
            end
          end
        end
        `ACRB_ADDR_OUT_FORMAT: begin
          st_next.out_format = reg_wdata;
          st_next.out_format[`ACRB_BIT_MUST_ZERO]  = 1'b0;
          st_next.out_format[`ACRB_BIT_OUT_DISABLE] = 1'b0;
          st_next.out_format[`ACRB_BIT_OUT_INVERT]  = 1'b0;
          for (int ch = 0; ch < 2; ch++) begin
            if (st_reg.chan_index[ch]) begin
              st_next.out_disable[ch] = reg_wdata[`ACRB_BIT_OUT_DISABLE];
              st_next.out_invert[ch]  = reg_wdata[`ACRB_BIT_OUT_INVERT];
            end
          end
        end
        `ACRB_ADDR_DIV_PHASE: begin
          st_next.div_phase = reg_wdata;
        end
        `ACRB_ADDR_DCO_DELAY: begin
          st_next.dco_delay = reg_wdata;
        end
        `ACRB_ADDR_REF_SPAN: begin
          st_next.ref_span = reg_wdata;
        end
        `ACRB_ADDR_DITHER: begin
          for (int ch = 0; ch < 2; ch++) begin
            if (st_reg.chan_index[ch]) begin
              st_next.dither[ch] = reg_wdata[`ACRB_BIT_DITHER];
            end
          end
        end
        `ACRB_ADDR_SYNC_CTRL: begin
          st_next.sync_ctrl = reg_wdata;
          wr_sync = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; unmapped addresses read as zero.
    if (reg_rd) begin
      st_next.rd_valid = 1'b1;
      case (reg_addr)
        `ACRB_ADDR_CHAN_INDEX:  st_next.rd_data = {6'h00, st_reg.chan_index};
        `ACRB_ADDR_SELF_TEST:   st_next.rd_data = st_reg.self_test;
        `ACRB_ADDR_ANALOG_IN:   st_next.rd_data = st_reg.analog_in;
        `ACRB_ADDR_OFFSET_TRIM: st_next.rd_data = st_reg.offset_trim[rc];
        `ACRB_ADDR_OUT_FORMAT: begin
          st_next.rd_data = st_reg.out_format;
          st_next.rd_data[`ACRB_BIT_OUT_DISABLE] = st_reg.out_disable[rc];
          st_next.rd_data[`ACRB_BIT_OUT_INVERT]  = st_reg.out_invert[rc];
        end
        `ACRB_ADDR_DIV_PHASE:   st_next.rd_data = st_reg.div_phase;
        `ACRB_ADDR_DCO_DELAY:   st_next.rd_data = st_reg.dco_delay;
        `ACRB_ADDR_REF_SPAN:    st_next.rd_data = st_reg.ref_span;
        `ACRB_ADDR_SIG_LOW:     st_next.rd_data = chan_sig[rc][7:0];
        `ACRB_ADDR_SIG_HIGH:    st_next.rd_data = chan_sig[rc][15:8];
        `ACRB_ADDR_DITHER: begin
          st_next.rd_data = `ACRB_RST_ZERO;
          st_next.rd_data[`ACRB_BIT_DITHER] = st_reg.dither[rc];
        end
        `ACRB_ADDR_SYNC_CTRL:   st_next.rd_data = st_reg.sync_ctrl;
        default:                st_next.rd_data = `ACRB_RST_ZERO;
      endcase
    end

    // A sync pulse reaches the divider only with master and divider enables both set.
    sync_gated = sync_in
               && st_reg.sync_ctrl[`ACRB_BIT_SYNC_MASTER]
               && st_reg.sync_ctrl[`ACRB_BIT_SYNC_DIVIDER];
    // One-shot mode drops the divider enable on the edge that takes the aligning pulse, as the hold begins; a write in that cycle wins.
    // A pulse that lands during a hold is not an alignment, so it must not clear the enable.
    if (sync_gated && st_reg.sync_ctrl[`ACRB_BIT_SYNC_NEXT] && st_reg.div_state == ACRB_DIV_RUN && !wr_sync) begin
      st_next.sync_ctrl[`ACRB_BIT_SYNC_DIVIDER] = 1'b0;
    end

    // Divider: a gated sync restarts it after the programmed phase delay.
    case (st_reg.div_state)
      ACRB_DIV_RUN: begin
        if (sync_gated) begin
          st_next.phase_cnt = st_reg.div_phase[2:0];
          st_next.div_cnt   = 3'h0;
          st_next.div_state = ACRB_DIV_HOLD;
        end else if (st_reg.div_cnt >= div_ratio) begin
          st_next.div_cnt  = 3'h0;
          st_next.div_tick = 1'b1;
        end else begin
          st_next.div_cnt = st_reg.div_cnt + 3'h1;
        end
      end
      ACRB_DIV_HOLD: begin
        // The tick that ends the hold lands phase_cnt + 1 cycles after the sync edge.
        if (st_reg.phase_cnt == 3'h0) begin
          st_next.div_tick  = 1'b1;
          st_next.div_cnt   = 3'h0;
          st_next.div_state = ACRB_DIV_RUN;
        end else begin
          st_next.phase_cnt = st_reg.phase_cnt - 3'h1;
        end
      end
      default: begin
        st_next.div_state = ACRB_DIV_RUN;
      end
    endcase
  end

  // ========================================================================
  // State register.
  // ========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg            <= '0;
      st_reg.chan_index <= `ACRB_RST_CHAN_INDEX;
      st_reg.self_test  <= `ACRB_RST_SELF_TEST;
      st_reg.ref_span   <= `ACRB_RST_REF_SPAN;
      st_reg.div_state  <= ACRB_DIV_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Outputs, all taken from stored state.
  // ========================================================================
  assign reg_rdata       = st_reg.rd_data;
  assign reg_rd_valid    = st_reg.rd_valid;
  assign div_tick        = st_reg.div_tick;
  assign out_enable      = ~st_reg.out_disable;
  assign out_lvds        = st_reg.out_format[`ACRB_BIT_OUT_LVDS];
  assign lvds_reduced    = st_reg.out_format[`ACRB_BIT_LVDS_SWING];
  assign out_interleave  = st_reg.out_format[`ACRB_BIT_INTERLEAVE];
  assign out_code_format = st_reg.out_format[1:0];
  assign dco_invert      = st_reg.div_phase[`ACRB_BIT_DCO_INVERT];
  assign dco_delay_code  = st_reg.dco_delay[4:0];
  assign dco_delay_ps    = dco_ps(st_reg.dco_delay[4:0]);
  assign ref_span        = st_reg.ref_span[7:6];
  assign st_enable       = st_reg.self_test[`ACRB_BIT_ST_ENABLE];
  assign st_restart      = st_reg.self_test[`ACRB_BIT_ST_SEQ_RESET];
  assign cm_servo_en     = st_reg.analog_in[`ACRB_BIT_CM_SERVO];
  assign dither_en       = st_reg.dither;
  assign sync_master_en  = st_reg.sync_ctrl[`ACRB_BIT_SYNC_MASTER];

endmodule : acrb_top

// *** core/acrb_cfg.svh ***
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH

// ==========================================================================
// Register addresses on the serial control port.
// ==========================================================================
`define ACRB_ADDR_CHAN_INDEX   9'h005
`define ACRB_ADDR_SELF_TEST    9'h00E
`define ACRB_ADDR_ANALOG_IN    9'h00F
`define ACRB_ADDR_OFFSET_TRIM  9'h010
`define ACRB_ADDR_OUT_FORMAT   9'h014
`define ACRB_ADDR_DIV_PHASE    9'h016
`define ACRB_ADDR_DCO_DELAY    9'h017
`define ACRB_ADDR_REF_SPAN     9'h018
`define ACRB_ADDR_SIG_LOW      9'h024
`define ACRB_ADDR_SIG_HIGH     9'h025
`define ACRB_ADDR_DITHER       9'h030
`define ACRB_ADDR_SYNC_CTRL    9'h100

// ==========================================================================
// Reset values.
// ==========================================================================
`define ACRB_RST_CHAN_INDEX    2'h3
`define ACRB_RST_SELF_TEST     8'h04
`define ACRB_RST_REF_SPAN      8'hC0
`define ACRB_RST_ZERO          8'h00

// ==========================================================================
// Field positions.
// ==========================================================================
`define ACRB_BIT_ST_ENABLE     0
`define ACRB_BIT_ST_SEQ_RESET  2
`define ACRB_BIT_CM_SERVO      0
`define ACRB_BIT_LVDS_SWING    7
`define ACRB_BIT_OUT_LVDS      6
`define ACRB_BIT_INTERLEAVE    5
`define ACRB_BIT_OUT_DISABLE   4
`define ACRB_BIT_MUST_ZERO     3
`define ACRB_BIT_OUT_INVERT    2
`define ACRB_BIT_DCO_INVERT    7
`define ACRB_BIT_DITHER        4
`define ACRB_BIT_SYNC_MASTER   0
`define ACRB_BIT_SYNC_DIVIDER  1
`define ACRB_BIT_SYNC_NEXT     2
`define ACRB_CHAN_A            0
`define ACRB_CHAN_B            1

// ==========================================================================
// Data clock output delay scale, in picoseconds.
// ==========================================================================
`define ACRB_DCO_FULL_PS       2500
`define ACRB_DCO_STEPS         31

// Signature feedback taps and the value it restarts from.
`define ACRB_SIG_TAPS          16'hD008
`define ACRB_SIG_SEED          16'h0000

`endif

// *** core/acrb_pkg.sv ***
package acrb_pkg;

  // ========================================================================
  // Divider alignment states, Gray coded along run -> hold -> run.
  // ========================================================================
  typedef enum logic [1:0] {
    ACRB_DIV_RUN  = 2'b00,
    ACRB_DIV_HOLD = 2'b01
  } acrb_div_state_type;

  // ========================================================================
  // Complete state of the register bank.
  // ========================================================================
  typedef struct packed {
    logic [1:0]         chan_index;
    logic [7:0]         self_test;
    logic [7:0]         analog_in;
    logic [1:0][7:0]    offset_trim;
    logic [1:0]         out_disable;
    logic [1:0]         out_invert;
    logic [7:0]         out_format;
    logic [7:0]         div_phase;
    logic [7:0]         dco_delay;
    logic [7:0]         ref_span;
    logic [1:0]         dither;
    logic [7:0]         sync_ctrl;
    logic [7:0]         rd_data;
    logic               rd_valid;
    acrb_div_state_type div_state;
    logic [2:0]         phase_cnt;
    logic [2:0]         div_cnt;
    logic               div_tick;
  } acrb_bank_type;

  // State of one channel's data path.
  typedef struct packed {
    logic [13:0] data;
    logic        valid;
    logic [15:0] signature;
  } acrb_chan_type;

endpackage : acrb_pkg

// *** core/acrb_chan_path.sv ***
`include "acrb_cfg.svh"

module acrb_chan_path
  import acrb_pkg::*;
#(
  parameter int DATA_W = 14
) (
  input  wire logic              clk,          // Core clock.
  input  wire logic              sys_rst,      // Synchronous reset, active high.
  input  wire logic              smp_valid,    // Conversion result present.
  input  wire logic [DATA_W-1:0] smp_data,     // Conversion result, twos complement.
  input  wire logic [7:0]        offset,       // Signed offset in LSBs.
  input  wire logic              invert,       // Invert output data.
  input  wire logic              st_enable,    // Self-test accumulation on.
  input  wire logic              st_restart,   // Hold signature at its seed.
  output logic                   out_valid,    // Corrected result present.
  output logic      [DATA_W-1:0] out_data,     // Corrected result.
  output logic      [15:0]       signature     // Self-test signature.
);

  acrb_chan_type st_reg;
  acrb_chan_type st_next;

  // Saturating signed add; wrapping would fold a near-full-scale input to the other rail.
  function automatic logic [DATA_W-1:0] sat_add(input logic [DATA_W-1:0] a, input logic [7:0] b);
    logic signed [DATA_W:0] sum;
    sum = $signed({a[DATA_W-1], a}) + $signed({{(DATA_W-7){b[7]}}, b});
    if (sum[DATA_W] != sum[DATA_W-1]) begin
      sat_add = sum[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}} : {1'b0, {(DATA_W-1){1'b1}}};
    end else begin
      sat_add = sum[DATA_W-1:0];
    end
  endfunction : sat_add

  // ========================================================================
  // Offset correction and signature accumulation.
  // ========================================================================
  always_comb begin
    logic [DATA_W-1:0] corr;
    corr    = sat_add(smp_data, offset);
    st_next = st_reg;
    st_next.valid = smp_valid;
    if (smp_valid) begin
      st_next.data = invert ? ~corr : corr;
    end
    // The signature covers the corrected result so the trim path is tested too.
    if (st_restart) begin
      st_next.signature = `ACRB_SIG_SEED;
    end else if (st_enable && smp_valid) begin
      st_next.signature = {st_reg.signature[14:0], ^(st_reg.signature & `ACRB_SIG_TAPS)}
                          ^ {{(16-DATA_W){1'b0}}, corr};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.valid;
  assign out_data  = st_reg.data;
  assign signature = st_reg.signature;

endmodule : acrb_chan_path

// *** sim/acrb_monitor.sv ***
`include "acrb_cfg.svh"

// ==========
// Port checks for the register bank.
module acrb_monitor (
  input wire logic        clk,            // Core clock.
  input wire logic        sys_rst,        // Sync reset.
  input wire logic        reg_wr,         // Write strobe.
  input wire logic [8:0]  reg_addr,       // Address.
  input wire logic [7:0]  reg_wdata,      // Write data.
  input wire logic [1:0]  smp_valid,      // Samples in.
  input wire logic [1:0]  out_valid,      // Samples out.
  input wire logic        out_lvds,       // LVDS chosen.
  input wire logic        lvds_reduced,   // Low swing.
  input wire logic [4:0]  dco_delay_code, // Delay code.
  input wire logic [11:0] dco_delay_ps,   // Delay in ps.
  input wire logic [1:0]  ref_span,       // Span code.
  input wire logic        st_enable,      // Self-test on.
  input wire logic        st_restart,     // Self-test reset.
  input wire logic        cm_servo_en,    // Servo on.
  input wire logic        sync_master_en  // Sync powered.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // One register write to a given address.
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence

  chk_lvds_select:
    assert property (s_wr(`ACRB_ADDR_OUT_FORMAT) |=> out_lvds == $past(reg_wdata[6]))
    else $error("Output type differs from write.");
  chk_swing_select:
    assert property (s_wr(`ACRB_ADDR_OUT_FORMAT) |=> lvds_reduced == $past(reg_wdata[7]))
    else $error("Swing differs from write.");
  chk_span_select:
    assert property (s_wr(`ACRB_ADDR_REF_SPAN) |=> ref_span == $past(reg_wdata[7:6]))
    else $error("Span differs from write.");
  chk_delay_scale:
    assert property (dco_delay_ps == 12'((2500 * dco_delay_code + 15) / 31))
    else $error("Delay value off scale.");
  chk_selftest_bits:
    assert property (s_wr(`ACRB_ADDR_SELF_TEST) |=> {st_restart, st_enable} == $past({reg_wdata[2], reg_wdata[0]}))
    else $error("Self-test bits differ from write.");
  chk_servo_bit:
    assert property (s_wr(`ACRB_ADDR_ANALOG_IN) |=> cm_servo_en == $past(reg_wdata[0]))
    else $error("Servo bit differs from write.");
  chk_sync_master:
    assert property (s_wr(`ACRB_ADDR_SYNC_CTRL) |=> sync_master_en == $past(reg_wdata[0]))
    else $error("Master sync differs from write.");
  chk_sample_answer:
    assert property (|smp_valid |=> out_valid == $past(smp_valid))
    else $error("Sample not answered next cycle.");
endmodule : acrb_monitor

// *** sim/acrb_host.sv ***
`include "acrb_cfg.svh"

// ==========
// Host on the register port; a released bus shows inverted values.
module acrb_host (
  input  wire logic clk,       // Core clock.
  output logic       reg_wr,    // Write strobe.
  output logic       reg_rd,    // Read strobe.
  output logic [8:0] reg_addr,  // Address.
  output logic [7:0] reg_wdata  // Write data.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
  end
  // The unused bit of the format register is always sent low.
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = (a == `ACRB_ADDR_OUT_FORMAT) ? (d & 8'hF7) : d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : acrb_host

// *** sim/test_adc_config_register_bank.sv ***
`include "acrb_cfg.svh"

module test_adc_config_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] exp; logic [15:0] msk;} acrb_note_type;
  logic clk, sys_rst, sync_in, reg_rd_valid, div_tick, out_lvds, lvds_reduced;
  logic st_enable, st_restart, cm_servo_en, sync_master_en, out_interleave, dco_invert;
  logic [1:0] out_code_format;
  logic [2:0] div_ratio;
  logic [1:0] smp_valid, out_valid, out_enable, ref_span, dither_en;
  logic [1:0][13:0] smp_data, out_data;
  logic [7:0] reg_rdata;
  logic [4:0] dco_delay_code;
  logic [11:0] dco_delay_ps;
  wire logic reg_wr, reg_rd;
  wire logic [8:0] reg_addr;
  wire logic [7:0] reg_wdata;
  acrb_note_type rq[$], dq[$];
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] r = 16'h0051;

  acrb_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  acrb_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sync_in(sync_in),
    .div_ratio(div_ratio), .div_tick(div_tick), .smp_valid(smp_valid), .smp_data(smp_data),
    .out_valid(out_valid), .out_data(out_data), .out_enable(out_enable), .out_lvds(out_lvds),
    .lvds_reduced(lvds_reduced), .out_interleave(out_interleave), .out_code_format(out_code_format),
    .dco_invert(dco_invert), .dco_delay_code(dco_delay_code), .dco_delay_ps(dco_delay_ps), .ref_span(ref_span),
    .st_enable(st_enable), .st_restart(st_restart), .cm_servo_en(cm_servo_en),
    .dither_en(dither_en), .sync_master_en(sync_master_en));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Offset sum clipped to the 14-bit signed range.
  function automatic logic [13:0] sat(input logic [13:0] x, input logic [7:0] o);
    int s;
    s = int'($signed(x)) + int'($signed(o));
    if (s > 8191) s = 8191;
    if (s < -8192) s = -8192;
    return s[13:0];
  endfunction : sat
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdx(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
    rq.push_back({8'h00, e, 8'h00, m});
    u_host.rd(a);
  endtask : rdx
  task automatic smp(input logic [13:0] a, input logic [13:0] b, input logic [13:0] ea, input logic [13:0] eb);
    dq.push_back({2'h0, ea, 16'hFFFF});
    dq.push_back({2'h0, eb, 16'hFFFF});
    @(negedge clk);
    smp_valid = 2'b11;
    smp_data = {b, a};
    @(negedge clk);
    smp_valid = 2'b00;
    smp_data = ~smp_data;
  endtask : smp
  // Pulses sync just after a tick, so the free-running divider gives a gap of eight.
  // The count starts half a cycle before the edge that takes the pulse, so phase p ends at p + 2.
  task automatic sync_gap(input int e);
    int n;
    n = 0;
    while (div_tick !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    sync_in = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      sync_in = 1'b0;
      n++;
    end while (div_tick !== 1'b1 && n < 20);
    chk(16'(n), 16'(e));
  endtask : sync_gap
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ==========
  // Results are compared oldest note first, as they leave the block.
  always @(negedge clk) begin
    acrb_note_type n;
    if (reg_rd_valid === 1'b1) begin
      n = rq.pop_front();
      chk({8'h00, reg_rdata & n.msk[7:0]}, n.exp);
    end
    for (int c = 0; c < 2; c++) if (out_valid[c] === 1'b1) begin
      n = dq.pop_front();
      chk({2'h0, out_data[c]}, n.exp);
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The whole sequence needs well under two thousand cycles.
  initial begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end

  // ==========
  // Main sequence.
  initial begin
    logic [8:0] ra[13] = '{9'h005, 9'h00E, 9'h00F, 9'h010, 9'h014, 9'h016, 9'h017, 9'h018, 9'h024, 9'h025,
      9'h030, 9'h100, 9'h1FF};
    logic [7:0] re[13] = '{8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wm[8] = '{8'h05, 8'h01, 8'hFF, 8'hF7, 8'h87, 8'h1F, 8'hC0, 8'h10};
    logic [11:0] dp[5] = '{12'd0, 12'd81, 12'd161, 12'd2419, 12'd2500};
    logic [4:0] dc[5] = '{5'd0, 5'd1, 5'd2, 5'd30, 5'd31};
    sys_rst = 1'b1;
    sync_in = 1'b0;
    div_ratio = 3'h7;
    smp_valid = 2'b00;
    smp_data = '0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk({7'h00, out_lvds, lvds_reduced, ref_span, out_enable, st_restart, st_enable, cm_servo_en}, 16'h007C);
    u_host.wr(9'h024, r[7:0]);
    u_host.wr(9'h025, r[15:8]);
    for (int i = 0; i < 13; i++) rdx(ra[i], re[i], 8'hFF);
    $display("end of test: reset values");
    for (int i = 1; i < 9; i++) begin
      r = lfsr(r);
      u_host.wr(ra[i == 8 ? 10 : i], r[7:0]);
      rdx(ra[i == 8 ? 10 : i], r[7:0] & wm[i - 1], wm[i - 1]);
    end
    for (int v = 0; v < 4; v++) begin
      u_host.wr(`ACRB_ADDR_OUT_FORMAT, {v[1:0], 6'h21});
      chk({11'h000, out_interleave, out_code_format, lvds_reduced, out_lvds}, 16'h0014 | 16'(v));
    end
    for (int i = 0; i < 5; i++) begin
      u_host.wr(`ACRB_ADDR_DCO_DELAY, {3'h0, dc[i]});
      chk({4'h0, dco_delay_ps}, {4'h0, dp[i]});
      chk({11'h000, dco_delay_code}, {11'h000, dc[i]});
    end
    for (int s = 0; s < 3; s++) begin
      u_host.wr(`ACRB_ADDR_REF_SPAN, {s[1:0], 6'h00});
      chk({14'h0, ref_span}, 16'(s));
    end
    $display("end of test: global fields");
    u_host.wr(`ACRB_ADDR_DITHER, 8'h10);
    u_host.wr(`ACRB_ADDR_CHAN_INDEX, 8'h01);
    u_host.wr(`ACRB_ADDR_OFFSET_TRIM, 8'hFB);
    u_host.wr(`ACRB_ADDR_OUT_FORMAT, 8'h04);
    u_host.wr(`ACRB_ADDR_DITHER, 8'h00);
    u_host.wr(`ACRB_ADDR_CHAN_INDEX, 8'h02);
    u_host.wr(`ACRB_ADDR_OFFSET_TRIM, 8'h7F);
    u_host.wr(`ACRB_ADDR_OUT_FORMAT, 8'h10);
    chk({12'h0, out_enable, dither_en}, 16'h0006);
    rdx(`ACRB_ADDR_OFFSET_TRIM, 8'h7F, 8'hFF);
    smp(14'd100, 14'd100, ~14'd95, 14'd227);
    smp(14'h2000, 14'h1FFF, ~14'h2000, 14'h1FFF);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      smp(r[13:0], ~r[13:0], ~sat(r[13:0], 8'hFB), sat(~r[13:0], 8'h7F));
    end
    $display("end of test: channel paths");
    u_host.wr(`ACRB_ADDR_DIV_PHASE, 8'h00);
    u_host.wr(`ACRB_ADDR_SYNC_CTRL, 8'h02);
    sync_gap(8);
    u_host.wr(`ACRB_ADDR_SYNC_CTRL, 8'h03);
    for (int p = 0; p < 8; p++) begin
      u_host.wr(`ACRB_ADDR_DIV_PHASE, 8'h80 | 8'(p));
      sync_gap(p + 2);
      chk({15'h0000, dco_invert}, 16'h0001);
    end
    u_host.wr(`ACRB_ADDR_DIV_PHASE, 8'h00);
    u_host.wr(`ACRB_ADDR_SYNC_CTRL, 8'h07);
    sync_gap(2);
    rdx(`ACRB_ADDR_SYNC_CTRL, 8'h05, 8'hFF);
    sync_gap(8);
    $display("end of test: divider sync");
    repeat (3) @(negedge clk);
    chk(16'(rq.size() + dq.size()), 16'h0000);
    summarize();
  end
endmodule : test_adc_config_register_bank

bind acrb_top acrb_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .smp_valid(smp_valid), .out_valid(out_valid), .out_lvds(out_lvds),
  .lvds_reduced(lvds_reduced), .dco_delay_code(dco_delay_code), .dco_delay_ps(dco_delay_ps),
  .ref_span(ref_span), .st_enable(st_enable), .st_restart(st_restart), .cm_servo_en(cm_servo_en),
  .sync_master_en(sync_master_en));
